// >>> hw/fault_ctl_pkg.sv
package fault_ctl_pkg;
   // Register byte addresses on the bus
   localparam logic [7:0] ADDR_INT_CFG = 8'h00;
   localparam logic [7:0] ADDR_CAL_SEL = 8'h04;
   localparam logic [7:0] ADDR_FAULT = 8'h08;
   localparam logic [7:0] ADDR_CONV = 8'h0C;
   localparam logic [7:0] ADDR_PIN_STAT = 8'h10;
   localparam int ADDR_LSB = 2;
   localparam int ADDR_MSB = 7;
   // Interrupt configuration and fault status bits
   localparam int BIT_CFG_D7 = 7;
   localparam int BIT_I_EN = 6;
   localparam int BIT_T_EN = 5;
   localparam int BIT_I_FLAG = 6;
   localparam int BIT_T_FLAG = 5;
   // Calibration select register fields
   localparam int CAL_LSB = 0;
   localparam int CAL_MSB = 1;
   localparam int BIT_TX_EN = 4;
   localparam int BIT_RX_EN = 5;
   // Pin status register bits
   localparam int ST_SHUTDOWN = 0;
   localparam int ST_SELECT = 1;
   localparam int ST_OVERCURRENT = 2;
   localparam int ST_THERMAL_OFF = 3;
   localparam int ST_AMP_ON = 4;
   // Reset values and calibration select codes
   localparam logic RESET_BIT = 1'b0;
   localparam logic [1:0] CAL_CODE_NONE = 2'h0;
   localparam logic [1:0] CAL_CODE_TX = 2'h1;
   localparam logic [1:0] CAL_CODE_RX = 2'h2;
   localparam logic [1:0] CAL_CODE_GAIN = 2'h3;
   localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

   typedef enum logic [3:0] {
      CAL_NONE = 4'h1,
      CAL_TX = 4'h2,
      CAL_RX = 4'h4,
      CAL_GAIN = 4'h8
   } cal_mode_type;

   typedef enum logic [1:0] {
      THERM_OK = 2'h1,
      THERM_OFF = 2'h2
   } therm_state_type;

   function automatic cal_mode_type cal_decode(input logic [1:0] code);
      cal_mode_type m;
      m = CAL_NONE;
      unique case (code)
         CAL_CODE_NONE: m = CAL_NONE;
         CAL_CODE_TX: m = CAL_TX;
         CAL_CODE_RX: m = CAL_RX;
         CAL_CODE_GAIN: m = CAL_GAIN;
      endcase
      return m;
   endfunction

   function automatic logic [31:0] lane_merge(input logic [31:0] old_w, input logic [31:0] new_w,
                                              input logic [3:0] sel);
      logic [31:0] r;
      r = old_w;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            r[b*8 +: 8] = new_w[b*8 +: 8];
         end
      end
      return r;
   endfunction

   function automatic logic word_hit(input logic [7:0] adr, input logic [7:0] base);
      return adr[ADDR_MSB:ADDR_LSB] == base[ADDR_MSB:ADDR_LSB];
   endfunction
endpackage

// >>> hw/pin_sync.sv
`timescale 1ns/1ps
module pin_sync #(
   parameter int WIDTH = 1
) (
   input wire logic i_clock,
   input wire logic i_rst_n,
   input wire logic [WIDTH-1:0] i_pins,
   output logic [WIDTH-1:0] o_levels
);
   logic [WIDTH-1:0] s1_reg;
   logic [WIDTH-1:0] s2_reg;
   logic [WIDTH-1:0] s3_reg;

   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         s1_reg <= '0;
         s2_reg <= '0;
         s3_reg <= '0;
      end else begin
         s1_reg <= i_pins;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
      end
   end

   // A change counts once stages two and three agree
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         o_levels <= '0;
      end else begin
         for (int i = 0; i < WIDTH; i++) begin
            if (s2_reg[i] == s3_reg[i]) begin
               o_levels[i] <= s3_reg[i];
            end
         end
      end
   end
endmodule

// >>> hw/fault_latch.sv
`timescale 1ns/1ps
module fault_latch (
   input wire logic i_clock,
   input wire logic i_rst_n,
   input wire logic i_fault,
   input wire logic i_enable,
   input wire logic i_clear,
   input wire logic i_hold,
   output logic o_flag
);
   // Sticky flag; a new fault beats a clear in the same cycle
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         o_flag <= fault_ctl_pkg::RESET_BIT;
      end else if (!i_hold) begin
         if (i_fault && i_enable) begin
            o_flag <= 1'b1;
         end else if (i_clear) begin
            o_flag <= 1'b0;
         end
      end
   end
endmodule

// >>> hw/fault_flag_and_control_pins.sv
// Operation
// RULE_01: Select pin steers each access target.
// RULE_02: Low selects converter, high selects command.
// RULE_03: Shutdown low means normal operation.
// RULE_04: Shutdown high stops everything, bus included.
// RULE_05: Registers keep their values through shutdown.
// RULE_06: Enabled overcurrent sets bit 6, interrupts.
// RULE_07: Overcurrent latch sticky until host clears.
// RULE_08: Disabled overcurrent limits only, no latch.
// RULE_09: Amplifier off above trip temperature.
// RULE_10: Enabled thermal fault sets bit 5, interrupts.
// RULE_11: Amplifier back on at resume temperature.
// RULE_12: Thermal latch sticky until host clears.
// RULE_13: Disabled thermal fault limits only, no latch.
// RULE_14: Interrupt is active low; host reads latches.
// RULE_15: Interrupt holds while enabled latch set.
// RULE_16: D7 written zero, D6/D5 enables, reset zero.
// RULE_17: Host writes bits 5-7 after power-on.
// RULE_18: Transmit ready released high when ready.
// RULE_19: Receive ready released high when ready.
// RULE_20: Three calibration modes from calibration register.
// RULE_21: Transmit calibration routes gain stage plus filter.
// RULE_22: Receive calibration routes full receive chain.
// RULE_23: Gain-stage calibration routes gain stage alone.
// RULE_24: Calibration optional, host keeps factors.
//
// Added by the designer: the placing of the registers and the Wishbone slave port.
`timescale 1ns/1ps
module fault_flag_and_control_pins #(
   parameter int CONV_WIDTH = 10
) (
   input wire logic i_clock,
   input wire logic i_rst_n,
   input wire logic i_wb_cyc,
   input wire logic i_wb_stb,
   input wire logic i_wb_we,
   input wire logic [7:0] i_wb_adr,
   input wire logic [31:0] i_wb_dat,
   input wire logic [3:0] i_wb_sel,
   output logic [31:0] o_wb_dat,
   output logic o_wb_ack,
   input wire logic i_register_select,
   input wire logic i_shutdown_pin,
   input wire logic i_overcurrent,
   input wire logic i_temp_above_trip,
   input wire logic i_temp_at_resume,
   input wire logic i_tx_path_ready,
   input wire logic i_rx_path_ready,
   output logic o_int_n,
   output logic o_tx_ready,
   output logic o_tx_ready_oe_n,
   output logic o_rx_ready,
   output logic o_rx_ready_oe_n,
   output logic o_amp_enable,
   output logic o_current_limit,
   output logic o_tx_enable,
   output logic o_rx_enable,
   output logic o_route_tx_cal,
   output logic o_route_rx_cal,
   output logic o_route_gain_cal,
   output logic [CONV_WIDTH-1:0] o_converter_code
);
   localparam int PIN_COUNT = 7;
   localparam int P_SELECT = 0;
   localparam int P_SHUTDOWN = 1;
   localparam int P_OVERCURRENT = 2;
   localparam int P_HOT = 3;
   localparam int P_COOL = 4;
   localparam int P_TX_READY = 5;
   localparam int P_RX_READY = 6;

   logic [PIN_COUNT-1:0] pin_levels;
   logic select_s;
   logic shutdown_s;
   logic overcurrent_s;
   logic hot_s;
   logic cool_s;
   logic tx_ready_s;
   logic rx_ready_s;

   logic cfg_d7_reg;
   logic i_en_reg;
   logic t_en_reg;
   logic [1:0] cal_code_reg;
   logic tx_en_reg;
   logic rx_en_reg;
   logic [CONV_WIDTH-1:0] conv_reg;
   logic i_flag;
   logic t_flag;
   fault_ctl_pkg::therm_state_type therm_reg;
   fault_ctl_pkg::therm_state_type therm_next;
   fault_ctl_pkg::cal_mode_type cal_mode;

   logic req;
   logic wr_cmd;
   logic wr_conv;
   logic clear_i;
   logic clear_t;
   logic [31:0] cfg_word;
   logic [31:0] cal_word;
   logic [31:0] fault_word;
   logic [31:0] conv_word;
   logic [31:0] stat_word;
   logic [31:0] cfg_wr;
   logic [31:0] cal_wr;
   logic [31:0] conv_wr;
   logic [31:0] rd_next;

   pin_sync #(
      .WIDTH(PIN_COUNT)
   ) u_pin_sync (
      .i_clock(i_clock),
      .i_rst_n(i_rst_n),
      .i_pins({i_rx_path_ready, i_tx_path_ready, i_temp_at_resume, i_temp_above_trip,
               i_overcurrent, i_shutdown_pin, i_register_select}),
      .o_levels(pin_levels)
   );

   assign select_s = pin_levels[P_SELECT];
   assign shutdown_s = pin_levels[P_SHUTDOWN];
   assign overcurrent_s = pin_levels[P_OVERCURRENT];
   assign hot_s = pin_levels[P_HOT];
   assign cool_s = pin_levels[P_COOL];
   assign tx_ready_s = pin_levels[P_TX_READY];
   assign rx_ready_s = pin_levels[P_RX_READY];

   // Bus request decode; in shutdown accesses are still acknowledged but no register is written or read
   assign req = i_wb_cyc && i_wb_stb && !o_wb_ack;
   assign wr_cmd = req && i_wb_we && !shutdown_s && select_s; // RULE_01 RULE_02 RULE_04
   assign wr_conv = req && i_wb_we && !shutdown_s && !select_s; // RULE_01 RULE_02 RULE_04

   // Current register images as bus words
   always_comb begin
      cfg_word = fault_ctl_pkg::WORD_ZERO;
      cfg_word[fault_ctl_pkg::BIT_CFG_D7] = cfg_d7_reg;
      cfg_word[fault_ctl_pkg::BIT_I_EN] = i_en_reg;
      cfg_word[fault_ctl_pkg::BIT_T_EN] = t_en_reg;
      cal_word = fault_ctl_pkg::WORD_ZERO;
      cal_word[fault_ctl_pkg::CAL_MSB:fault_ctl_pkg::CAL_LSB] = cal_code_reg;
      cal_word[fault_ctl_pkg::BIT_TX_EN] = tx_en_reg;
      cal_word[fault_ctl_pkg::BIT_RX_EN] = rx_en_reg;
      fault_word = fault_ctl_pkg::WORD_ZERO;
      fault_word[fault_ctl_pkg::BIT_I_FLAG] = i_flag;
      fault_word[fault_ctl_pkg::BIT_T_FLAG] = t_flag;
      conv_word = fault_ctl_pkg::WORD_ZERO;
      conv_word[CONV_WIDTH-1:0] = conv_reg;
      stat_word = fault_ctl_pkg::WORD_ZERO;
      stat_word[fault_ctl_pkg::ST_SHUTDOWN] = shutdown_s;
      stat_word[fault_ctl_pkg::ST_SELECT] = select_s;
      stat_word[fault_ctl_pkg::ST_OVERCURRENT] = overcurrent_s;
      stat_word[fault_ctl_pkg::ST_THERMAL_OFF] = (therm_reg == fault_ctl_pkg::THERM_OFF);
      stat_word[fault_ctl_pkg::ST_AMP_ON] = o_amp_enable;
   end

   assign cfg_wr = fault_ctl_pkg::lane_merge(cfg_word, i_wb_dat, i_wb_sel);
   assign cal_wr = fault_ctl_pkg::lane_merge(cal_word, i_wb_dat, i_wb_sel);
   assign conv_wr = fault_ctl_pkg::lane_merge(conv_word, i_wb_dat, i_wb_sel);

   // Interrupt configuration register
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         cfg_d7_reg <= fault_ctl_pkg::RESET_BIT; // RULE_16
         i_en_reg <= fault_ctl_pkg::RESET_BIT; // RULE_16
         t_en_reg <= fault_ctl_pkg::RESET_BIT; // RULE_16
      end else if (wr_cmd && fault_ctl_pkg::word_hit(i_wb_adr, fault_ctl_pkg::ADDR_INT_CFG)) begin
         cfg_d7_reg <= cfg_wr[fault_ctl_pkg::BIT_CFG_D7];
         i_en_reg <= cfg_wr[fault_ctl_pkg::BIT_I_EN]; // RULE_16
         t_en_reg <= cfg_wr[fault_ctl_pkg::BIT_T_EN]; // RULE_16
      end
   end

   // Calibration select and path enables
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         cal_code_reg <= fault_ctl_pkg::CAL_CODE_NONE;
         tx_en_reg <= fault_ctl_pkg::RESET_BIT;
         rx_en_reg <= fault_ctl_pkg::RESET_BIT;
      end else if (wr_cmd && fault_ctl_pkg::word_hit(i_wb_adr, fault_ctl_pkg::ADDR_CAL_SEL)) begin
         cal_code_reg <= cal_wr[fault_ctl_pkg::CAL_MSB:fault_ctl_pkg::CAL_LSB]; // RULE_20
         tx_en_reg <= cal_wr[fault_ctl_pkg::BIT_TX_EN];
         rx_en_reg <= cal_wr[fault_ctl_pkg::BIT_RX_EN];
      end
   end

   // Converter register, write-only target when select is low
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         conv_reg <= '0;
      end else if (wr_conv && fault_ctl_pkg::word_hit(i_wb_adr, fault_ctl_pkg::ADDR_CONV)) begin
         conv_reg <= conv_wr[CONV_WIDTH-1:0]; // RULE_01
      end
   end

   // Write one to a flag bit clears it
   assign clear_i = wr_cmd && fault_ctl_pkg::word_hit(i_wb_adr, fault_ctl_pkg::ADDR_FAULT)
                    && i_wb_sel[0] && i_wb_dat[fault_ctl_pkg::BIT_I_FLAG];
   assign clear_t = wr_cmd && fault_ctl_pkg::word_hit(i_wb_adr, fault_ctl_pkg::ADDR_FAULT)
                    && i_wb_sel[0] && i_wb_dat[fault_ctl_pkg::BIT_T_FLAG];

   fault_latch u_current_latch (
      .i_clock(i_clock),
      .i_rst_n(i_rst_n),
      .i_fault(overcurrent_s), // RULE_06 RULE_07 RULE_08
      .i_enable(i_en_reg),
      .i_clear(clear_i),
      .i_hold(shutdown_s), // RULE_05
      .o_flag(i_flag)
   );

   fault_latch u_thermal_latch (
      .i_clock(i_clock),
      .i_rst_n(i_rst_n),
      .i_fault(therm_reg == fault_ctl_pkg::THERM_OFF), // RULE_10 RULE_12 RULE_13
      .i_enable(t_en_reg),
      .i_clear(clear_t),
      .i_hold(shutdown_s), // RULE_05
      .o_flag(t_flag)
   );

   // Thermal protection with hysteresis
   always_comb begin
      therm_next = therm_reg;
      unique case (therm_reg)
         fault_ctl_pkg::THERM_OK: begin
            if (hot_s) begin
               therm_next = fault_ctl_pkg::THERM_OFF; // RULE_09
            end
         end
         fault_ctl_pkg::THERM_OFF: begin
            if (cool_s && !hot_s) begin
               therm_next = fault_ctl_pkg::THERM_OK; // RULE_11
            end
         end
         default: therm_next = fault_ctl_pkg::THERM_OFF;
      endcase
   end

   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         therm_reg <= fault_ctl_pkg::THERM_OK;
      end else begin
         therm_reg <= therm_next;
      end
   end

   // Bus answer and read data
   always_comb begin
      rd_next = fault_ctl_pkg::WORD_ZERO;
      if (req && !i_wb_we && !shutdown_s && select_s) begin // RULE_01 RULE_04
         if (fault_ctl_pkg::word_hit(i_wb_adr, fault_ctl_pkg::ADDR_INT_CFG)) begin
            rd_next = cfg_word;
         end else if (fault_ctl_pkg::word_hit(i_wb_adr, fault_ctl_pkg::ADDR_CAL_SEL)) begin
            rd_next = cal_word;
         end else if (fault_ctl_pkg::word_hit(i_wb_adr, fault_ctl_pkg::ADDR_FAULT)) begin
            rd_next = fault_word; // RULE_14
         end else if (fault_ctl_pkg::word_hit(i_wb_adr, fault_ctl_pkg::ADDR_PIN_STAT)) begin
            rd_next = stat_word;
         end
      end
   end

   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         o_wb_ack <= 1'b0;
         o_wb_dat <= fault_ctl_pkg::WORD_ZERO;
      end else begin
         o_wb_ack <= req;
         o_wb_dat <= rd_next;
      end
   end

   // Interrupt output, low while an enabled latch is set
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         o_int_n <= 1'b1;
      end else begin
         o_int_n <= !((i_flag && i_en_reg) || (t_flag && t_en_reg)); // RULE_14 RULE_15
      end
   end

   // Amplifier, limit and path enables
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         o_amp_enable <= 1'b0;
         o_current_limit <= 1'b0;
         o_tx_enable <= 1'b0;
         o_rx_enable <= 1'b0;
      end else begin
         o_amp_enable <= (therm_reg == fault_ctl_pkg::THERM_OK) && !shutdown_s; // RULE_03 RULE_09 RULE_11
         o_current_limit <= overcurrent_s; // RULE_08
         o_tx_enable <= tx_en_reg && !shutdown_s; // RULE_03 RULE_04
         o_rx_enable <= rx_en_reg && !shutdown_s; // RULE_03 RULE_04
      end
   end

   // Open-drain readiness pins; enable low pulls the pin low
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         o_tx_ready <= 1'b0;
         o_rx_ready <= 1'b0;
         o_tx_ready_oe_n <= 1'b0;
         o_rx_ready_oe_n <= 1'b0;
      end else begin
         o_tx_ready <= 1'b0;
         o_rx_ready <= 1'b0;
         o_tx_ready_oe_n <= tx_en_reg && tx_ready_s && !shutdown_s; // RULE_18
         o_rx_ready_oe_n <= rx_en_reg && rx_ready_s && !shutdown_s; // RULE_19
      end
   end

   // Calibration signal routing
   assign cal_mode = fault_ctl_pkg::cal_decode(cal_code_reg);

   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         o_route_tx_cal <= 1'b0;
         o_route_rx_cal <= 1'b0;
         o_route_gain_cal <= 1'b0;
      end else begin
         o_route_tx_cal <= (cal_mode == fault_ctl_pkg::CAL_TX) && !shutdown_s; // RULE_21
         o_route_rx_cal <= (cal_mode == fault_ctl_pkg::CAL_RX) && !shutdown_s; // RULE_22
         o_route_gain_cal <= (cal_mode == fault_ctl_pkg::CAL_GAIN) && !shutdown_s; // RULE_23
      end
   end

   assign o_converter_code = conv_reg;

   property p_conv_guard;
      @(posedge i_clock) disable iff (!i_rst_n)
      (req && i_wb_we && select_s) |=> $stable(conv_reg);
   endproperty
   a_conv_guard: assert property (p_conv_guard) // RULE_01
      else $error("converter written while command target selected");

   property p_cmd_guard;
      @(posedge i_clock) disable iff (!i_rst_n)
      (req && i_wb_we && !select_s) |=> ($stable(i_en_reg) && $stable(t_en_reg) && $stable(cal_code_reg));
   endproperty
   a_cmd_guard: assert property (p_cmd_guard) // RULE_02
      else $error("command register written while converter selected");

   property p_retain;
      @(posedge i_clock) disable iff (!i_rst_n)
      shutdown_s |=> ($stable(i_en_reg) && $stable(conv_reg) && $stable(i_flag) && $stable(t_flag));
   endproperty
   a_retain: assert property (p_retain) // RULE_05
      else $error("register changed during shutdown");

   property p_oc_set;
      @(posedge i_clock) disable iff (!i_rst_n)
      (overcurrent_s && i_en_reg && !shutdown_s) |=> i_flag ##1 (!o_int_n || !$past(i_en_reg));
   endproperty
   a_oc_set: assert property (p_oc_set) // RULE_06
      else $error("overcurrent did not latch and interrupt");

   property p_oc_sticky;
      @(posedge i_clock) disable iff (!i_rst_n)
      (i_flag && !clear_i) |=> i_flag;
   endproperty
   a_oc_sticky: assert property (p_oc_sticky) // RULE_07
      else $error("overcurrent latch fell without clear");

   property p_oc_masked;
      @(posedge i_clock) disable iff (!i_rst_n)
      (!i_en_reg && !clear_i) |=> $stable(i_flag);
   endproperty
   a_oc_masked: assert property (p_oc_masked) // RULE_08
      else $error("masked overcurrent changed the latch");

   property p_hot_off;
      @(posedge i_clock) disable iff (!i_rst_n)
      hot_s |=> ##1 !o_amp_enable;
   endproperty
   a_hot_off: assert property (p_hot_off) // RULE_09
      else $error("amplifier on while over temperature");

   property p_int_level;
      @(posedge i_clock) disable iff (!i_rst_n)
      ((i_flag && i_en_reg) || (t_flag && t_en_reg)) |=> !o_int_n;
   endproperty
   a_int_level: assert property (p_int_level) // RULE_15
      else $error("interrupt not low with enabled latch set");

   property p_tx_pull;
      @(posedge i_clock) disable iff (!i_rst_n)
      !(tx_en_reg && tx_ready_s) |=> !o_tx_ready_oe_n;
   endproperty
   a_tx_pull: assert property (p_tx_pull) // RULE_18
      else $error("transmit ready released while not ready");

   property p_route_one;
      @(posedge i_clock) disable iff (!i_rst_n)
      $onehot0({o_route_tx_cal, o_route_rx_cal, o_route_gain_cal});
   endproperty
   a_route_one: assert property (p_route_one) // RULE_20
      else $error("more than one calibration route active");
endmodule

// >>> test/analog_plant_model.sv
`timescale 1ns/1ps
module analog_plant_model (
   input wire logic i_clock,
   input wire logic [7:0] i_temperature,
   output logic o_temp_above_trip,
   output logic o_temp_at_resume
);
   // Detector thresholds in degrees C
   localparam logic [7:0] TRIP_C = 8'h96;
   localparam logic [7:0] RESUME_C = 8'h87;
   always @(posedge i_clock) begin
      o_temp_above_trip <= i_temperature > TRIP_C;
      o_temp_at_resume <= i_temperature <= RESUME_C;
   end
endmodule

// >>> test/fault_flag_and_control_pins_bench.sv
`timescale 1ns/1ps
module fault_flag_and_control_pins_bench;
   logic i_clock = 1'b0;
   logic i_rst_n = 1'b0;
   logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] wdat = 32'h0000_0000;
   logic [3:0] sel = 4'h0;
   logic rsel = 1'b1, shutdown_pin = 1'b0, oc = 1'b0, txr = 1'b0, rxr = 1'b0;
   logic [7:0] temp = 8'h19;
   logic above, resume;
   logic [31:0] o_wb_dat;
   logic o_wb_ack, int_n, oe_tx, oe_rx, amp, limit, txen, rxen, rt, rr, rg;
   logic txo, rxo;
   logic [9:0] conv;
   logic [15:0] rnd = 16'h59f5;
   int fail_count = 0;
   int cmp_count = 0;
   int ticks = 0;

   always #25 i_clock = ~i_clock;

   fault_flag_and_control_pins #(.CONV_WIDTH(10)) u_fault_flag_and_control_pins (
      .i_clock(i_clock), .i_rst_n(i_rst_n), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
      .i_wb_adr(adr), .i_wb_dat(wdat), .i_wb_sel(sel), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack),
      .i_register_select(rsel), .i_shutdown_pin(shutdown_pin), .i_overcurrent(oc),
      .i_temp_above_trip(above), .i_temp_at_resume(resume), .i_tx_path_ready(txr),
      .i_rx_path_ready(rxr), .o_int_n(int_n), .o_tx_ready(txo), .o_tx_ready_oe_n(oe_tx),
      .o_rx_ready(rxo), .o_rx_ready_oe_n(oe_rx), .o_amp_enable(amp), .o_current_limit(limit),
      .o_tx_enable(txen), .o_rx_enable(rxen), .o_route_tx_cal(rt), .o_route_rx_cal(rr),
      .o_route_gain_cal(rg), .o_converter_code(conv));

   analog_plant_model u_analog_plant_model (.i_clock(i_clock), .i_temperature(temp),
      .o_temp_above_trip(above), .o_temp_at_resume(resume));

   function automatic logic [15:0] lfsr(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction

   function automatic logic [31:0] exp_route(input logic [1:0] m);
      return {29'h0000_0000, m == 2'h3, m == 2'h2, m == 2'h1};
   endfunction

   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, e, g);
      end
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge i_clock);
      @(negedge i_clock);
   endtask

   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      int n;
      n = 0;
      @(posedge i_clock);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      sel <= 4'hf;
      // Ack and read data are taken at the rising edge that sees ack high
      do begin
         @(posedge i_clock);
         n++;
      end while (o_wb_ack !== 1'b1);
      q = o_wb_dat;
      cyc <= 1'b0;
      stb <= 1'b0;
      chk("bus ack delay", 2, n);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      wb(1'b1, a, d, q);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input string what);
      logic [31:0] q;
      wb(1'b0, a, 32'h0000_0000, q);
      chk(what, e, q & m);
   endtask

   task automatic done(input string what);
      $display("test %s finished", what);
   endtask

   always @(posedge i_clock) begin
      ticks++;
      if (ticks == 5000) begin
         fail_count++;
         stop_test();
      end
   end

   initial begin
      repeat (8) @(posedge i_clock);
      i_rst_n <= 1'b1;
      idle(6);
      chk("int_n idle", 1, int_n);
      rd(fault_ctl_pkg::ADDR_INT_CFG, 32'h0000_0060, 0, "cfg reset");
      rd(fault_ctl_pkg::ADDR_FAULT, 32'h0000_0060, 0, "flags reset");
      rd(8'h1c, 32'hffff_ffff, 0, "unmapped");
      wr(fault_ctl_pkg::ADDR_INT_CFG, 32'h0000_0000);
      rd(fault_ctl_pkg::ADDR_INT_CFG, 32'h0000_00e0, 0, "cfg setup");
      done("reset");
      for (int m = 0; m < 4; m++) begin
         rnd = lfsr(rnd);
         @(posedge i_clock);
         txr <= rnd[0];
         rxr <= rnd[1];
         wr(fault_ctl_pkg::ADDR_CAL_SEL, {26'h0, rnd[3:2], 2'h0, m[1:0]});
         idle(7);
         chk("routes", exp_route(m[1:0]), {29'h0, rg, rr, rt});
         chk("tx ready", rnd[2] & rnd[0], oe_tx);
         chk("rx ready", rnd[3] & rnd[1], oe_rx);
         chk("tx enable", rnd[2], txen);
         chk("rx enable", rnd[3], rxen);
         chk("od level", 0, {txo, rxo});
      end
      done("calibration");
      for (int en = 0; en < 2; en++) begin
         wr(fault_ctl_pkg::ADDR_INT_CFG, {25'h0, en[0], 6'h0});
         @(posedge i_clock);
         oc <= 1'b1;
         idle(8);
         chk("limit", 1, limit);
         chk("int_n oc", !en[0], int_n);
         @(posedge i_clock);
         oc <= 1'b0;
         idle(8);
         chk("limit off", 0, limit);
         rd(fault_ctl_pkg::ADDR_FAULT, 32'h0000_0060, {25'h0, en[0], 6'h0}, "oc latch");
         chk("int_n held", !en[0], int_n);
      end
      wr(fault_ctl_pkg::ADDR_FAULT, 32'h0000_0040);
      idle(3);
      chk("int_n clear", 1, int_n);
      rd(fault_ctl_pkg::ADDR_FAULT, 32'h0000_0060, 0, "oc cleared");
      done("overcurrent");
      for (int en = 0; en < 2; en++) begin
         wr(fault_ctl_pkg::ADDR_INT_CFG, {26'h0, en[0], 5'h0});
         @(posedge i_clock);
         temp <= 8'ha0;
         idle(8);
         chk("amp off", 0, amp);
         chk("int_n th", !en[0], int_n);
         @(posedge i_clock);
         temp <= 8'h8c;
         idle(8);
         chk("amp hyst", 0, amp);
         @(posedge i_clock);
         temp <= 8'h80;
         idle(8);
         chk("amp back", 1, amp);
         rd(fault_ctl_pkg::ADDR_FAULT, 32'h0000_0060, {26'h0, en[0], 5'h0}, "th latch");
      end
      done("thermal");
      wr(fault_ctl_pkg::ADDR_INT_CFG, 32'h0000_0040);
      @(posedge i_clock);
      shutdown_pin <= 1'b1;
      idle(6);
      chk("amp shutdown", 0, amp);
      chk("tx en shutdown", 0, txen);
      wr(fault_ctl_pkg::ADDR_INT_CFG, 32'h0000_0020);
      rd(fault_ctl_pkg::ADDR_INT_CFG, 32'hffff_ffff, 0, "shutdown read");
      @(posedge i_clock);
      shutdown_pin <= 1'b0;
      idle(6);
      rd(fault_ctl_pkg::ADDR_INT_CFG, 32'h0000_00e0, 32'h0000_0040, "kept");
      chk("amp resumed", 1, amp);
      done("shutdown");
      wr(fault_ctl_pkg::ADDR_FAULT, 32'h0000_0020);
      rnd = lfsr(rnd);
      wr(fault_ctl_pkg::ADDR_CONV, {22'h0, rnd[9:0]});
      idle(1);
      chk("conv ignored", 0, conv);
      @(posedge i_clock);
      rsel <= 1'b0;
      idle(6);
      wr(fault_ctl_pkg::ADDR_CONV, {22'h0, rnd[9:0]});
      idle(1);
      chk("conv", rnd[9:0], conv);
      rd(fault_ctl_pkg::ADDR_INT_CFG, 32'hffff_ffff, 0, "sel low read");
      done("select");
      stop_test();
   end
endmodule
